// ---- serial_pkg.sv ----
// constants, register map and types shared by the serial port design files
// assumes byte-wide registers reached over a plain strobe port
package serial_pkg;

   // register indices on the plain register port
   localparam logic [3:0] OFS_TX_CONTROL_STATUS   = 4'h0;
   localparam logic [3:0] OFS_RX_CONTROL_STATUS   = 4'h1;
   localparam logic [3:0] OFS_BAUD_CONTROL        = 4'h2;
   localparam logic [3:0] OFS_TX_HOLDING          = 4'h3;
   localparam logic [3:0] OFS_DIVIDER_HIGH_BYTE   = 4'h4;
   localparam logic [3:0] OFS_DIVIDER_LOW_BYTE    = 4'h5;
   localparam logic [3:0] OFS_PERIPHERAL_FLAGS    = 4'h6;
   localparam logic [3:0] OFS_PERIPHERAL_ENABLES  = 4'h7;
   localparam logic [3:0] OFS_PERIPHERAL_PRIORITY = 4'h8;
   localparam logic [3:0] OFS_RECEIVE_BUFFER      = 4'h9;

   // tx_control_status fields
   localparam int BIT_CLOCK_SOURCE     = 7;
   localparam int BIT_NINTH_BIT_ENABLE = 6;
   localparam int BIT_TRANSMIT_ENABLE  = 5;
   localparam int BIT_LOCKSTEP         = 4;
   localparam int BIT_BREAK_SEND       = 3;
   localparam int BIT_HIGH_SPEED       = 2;
   localparam int BIT_SHIFTER_EMPTY    = 1;
   localparam int BIT_NINTH_BIT_VALUE  = 0;
   // rx_control_status fields
   localparam int BIT_PORT_ENABLE      = 7;
   // baud_control fields
   localparam int BIT_RECEIVE_ACTIVE   = 6;
   localparam int BIT_CLOCK_POLARITY   = 4;
   localparam int BIT_SIXTEEN_BIT_DIV  = 3;
   localparam int BIT_WAKE_ARM         = 1;
   localparam int BIT_AUTO_BAUD_DETECT = 0;
   // peripheral flags / enables fields
   localparam int BIT_RECEIVE_FLAG     = 5;
   localparam int BIT_TRANSMIT_FLAG    = 4;

   // writable bit masks; unimplemented bits read as zero, read-only status bits read their status
   localparam logic [7:0] MASK_TX_CONTROL = 8'hfd;
   localparam logic [7:0] MASK_RX_CONTROL = 8'hf8;
   localparam logic [7:0] MASK_BAUD       = 8'h1b;
   localparam logic [7:0] MASK_PERIPH     = 8'h7b;

   // values after reset
   localparam logic [7:0] RST_CONTROL     = 8'h00;
   localparam logic [7:0] RST_DIVIDER     = 8'h00;
   localparam logic       RST_TX_FLAG     = 1'b1;
   localparam logic       RST_LINE_LEVEL  = 1'b1;

   // frame shapes, counted in bits
   localparam logic [3:0] BREAK_ZERO_BITS = 4'hc;
   localparam logic [3:0] BREAK_BITS      = 4'he;
   localparam logic [3:0] SYNC_BITS_8     = 4'h8;
   localparam logic [3:0] SYNC_BITS_9     = 4'h9;
   localparam logic [3:0] ASYNC_BITS_8    = 4'ha;
   localparam logic [3:0] ASYNC_BITS_9    = 4'hb;
   // divider ticks per bit: one tick for each half of the divider output
   localparam int         TICKS_PER_BIT   = 2;
   // receive activity is reported for one nominal ten-bit frame
   localparam logic [4:0] RX_FRAME_TICKS  = 5'd20;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT
   } tx_state_t;

endpackage : serial_pkg

// ---- baud_if.sv ----
// carrier between the serial port core and its baud divider
// the core supplies divisor and run, the divider returns a one-cycle tick
`timescale 1ns/1ps
interface baud_if;
   logic [15:0] divisor;
   logic        run;
   logic        tick;

   modport core (
      output divisor,
      output run,
      input  tick
   );

   modport gen (
      input  divisor,
      input  run,
      output tick
   );
endinterface : baud_if

// ---- input_sync.sv ----
// two-stage synchroniser for pins arriving from outside the core clock
// assumes the pin changes slowly compared with the core clock
`timescale 1ns/1ps
module input_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // pin and synchronised level
   input  wire logic i_pin,
   output logic      o_level
);
   typedef struct packed {
      logic meta;
      logic level;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   // the first stage feeds only the second stage
   always_comb begin
      d       = q;
      d.meta  = i_pin;
      d.level = q.meta;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= {RESET_LEVEL, RESET_LEVEL};
      end else begin
         q <= d;
      end
   end

   assign o_level = q.level;
endmodule : input_sync

// ---- baud_divider.sv ----
// free-running baud divider: one tick every divisor plus one core cycles
// assumes the divisor is held stable by software while a frame runs
`timescale 1ns/1ps
module baud_divider #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // divisor in, tick out
   baud_if.gen       bus
);
   // refuse widths that the divisor carrier cannot serve
   if (WIDTH < 8 || WIDTH > 16) begin : g_bad_width
      $error("baud_divider: WIDTH must lie between 8 and 16");
   end

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             tick;
   } div_state_t;

   div_state_t q;
   div_state_t d;

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (!bus.run) begin
         d.count = bus.divisor[WIDTH-1:0];
      end else if (q.count == '0) begin
         d.count = bus.divisor[WIDTH-1:0];
         d.tick  = 1'b1;
      end else begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.tick = q.tick;
endmodule : baud_divider

// ---- serial_break_sync_master_tx.sv ----
// serial port transmit core: holding buffer, transmit shifter, break characters,
// synchronous master clock, auto-wake arming and the byte-wide register file
// assumes a register master on the core clock and pins outside that clock
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module serial_break_sync_master_tx
   import serial_pkg::*;
(
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   // register port
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr_stb,
   input  wire logic       i_rd_stb,
   output logic [7:0]      o_rd_data,
   // receive / data pin, two-way
   input  wire logic       i_receive_data_pin,
   output logic            o_data_line,
   output logic            o_data_line_oe_n,
   // transmit / clock pin, two-way
   output logic            o_clock_pin,
   output logic            o_clock_pin_oe_n,
   // status levels
   output logic            o_transmit_flag,
   output logic            o_receive_flag
);

   typedef struct packed {
      logic [7:0]  tx_ctrl;
      logic [7:0]  rx_ctrl;
      logic [7:0]  baud_ctrl;
      logic [7:0]  div_high;
      logic [7:0]  div_low;
      logic [7:0]  enables;
      logic [7:0]  prio;
      logic [7:0]  hold_data;
      logic        hold_ninth;
      logic        hold_full;
      logic        tx_flag;
      logic        rx_flag;
      logic        wake_seen;
      logic        rx_prev;
      logic        rx_active;
      logic [4:0]  rx_count;
      tx_state_t   state;
      logic [13:0] shifter;
      logic [3:0]  bits_left;
      logic        phase;
      logic        is_break;
      logic        line;
      logic        sclk_active;
      logic [7:0]  rd_data;
      logic        clk_pin;
      logic        clk_oe_n;
      logic        data_pin;
      logic        data_oe_n;
   } core_state_t;

   core_state_t q;
   core_state_t d;

   logic rx_level;
   logic fall;
   logic rise;
   logic lockstep;
   logic master;
   logic port_on;
   logic tx_on;
   logic tick;

   baud_if baud ();

   input_sync #(
      .RESET_LEVEL (RST_LINE_LEVEL)
   ) u_rx_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_pin      (i_receive_data_pin),
      .o_level    (rx_level)
   );

   baud_divider #(
      .WIDTH (16)
   ) u_divider (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .bus        (baud.gen)
   );

   assign baud.divisor = q.baud_ctrl[BIT_SIXTEEN_BIT_DIV] ? {q.div_high, q.div_low} : {8'h00, q.div_low};
   assign baud.run     = q.rx_ctrl[BIT_PORT_ENABLE];
   assign tick         = baud.tick;

   // rx_prev resets to the idle level, so no false edge follows reset
   assign fall     = q.rx_prev & ~rx_level;
   assign rise     = ~q.rx_prev & rx_level;
   assign lockstep = q.tx_ctrl[BIT_LOCKSTEP];
   assign master   = q.tx_ctrl[BIT_CLOCK_SOURCE];
   assign port_on  = q.rx_ctrl[BIT_PORT_ENABLE];
   assign tx_on    = q.tx_ctrl[BIT_TRANSMIT_ENABLE] & port_on;

   always_comb begin
      d         = q;
      d.rd_data = 8'h00;
      d.rx_prev = rx_level;

      if (q.state == ST_IDLE) begin
         // reload only from an empty shifter
         if (q.hold_full && tx_on && !q.rx_active) begin
            d.hold_full = 1'b0;
            d.state     = ST_SHIFT;
            d.phase     = 1'b0;
            if (q.tx_ctrl[BIT_BREAK_SEND]) begin
               d.shifter   = {1'b1, 13'h0000};
               d.bits_left = BREAK_BITS;
               d.is_break  = 1'b1;
            end else if (lockstep) begin
               d.shifter   = {5'h00, q.hold_ninth, q.hold_data};
               d.bits_left = q.tx_ctrl[BIT_NINTH_BIT_ENABLE] ? SYNC_BITS_9 : SYNC_BITS_8;
               d.is_break  = 1'b0;
            end else if (q.tx_ctrl[BIT_NINTH_BIT_ENABLE]) begin
               d.shifter   = {3'h0, 1'b1, q.hold_ninth, q.hold_data, 1'b0};
               d.bits_left = ASYNC_BITS_9;
               d.is_break  = 1'b0;
            end else begin
               d.shifter   = {4'h0, 1'b1, q.hold_data, 1'b0};
               d.bits_left = ASYNC_BITS_8;
               d.is_break  = 1'b0;
            end
         end
      end else begin
         if (!tx_on) begin
            // dropping the enable abandons the frame; the line returns to idle
            d.state       = ST_IDLE;
            d.line        = RST_LINE_LEVEL;
            d.sclk_active = 1'b0;
         end else if (tick) begin
            // lsb first, two divider ticks per bit
            if (!q.phase) begin
               d.line        = q.shifter[0];
               d.sclk_active = 1'b1;
               d.phase       = 1'b1;
            end else begin
               d.sclk_active = 1'b0;
               d.shifter     = {1'b0, q.shifter[13:1]};
               d.bits_left   = q.bits_left - 4'h1;
               d.phase       = 1'b0;
               if (q.bits_left == 4'h1) begin
                  // shifter_empty returns after last bit, break or not
                  d.state = ST_IDLE;
                  // a synchronous slave samples as the clock returns to idle, so the
                  // data line keeps its last bit there rather than changing under it
                  if (!lockstep) begin
                     d.line = RST_LINE_LEVEL;
                  end
                  // break_send clears after the break stop bit
                  if (q.is_break) begin
                     d.tx_ctrl[BIT_BREAK_SEND] = 1'b0;
                     d.is_break                = 1'b0;
                  end
               end
            end
         end
      end

      // receive activity lasts one nominal frame after a start edge
      if (!port_on || lockstep || q.baud_ctrl[BIT_WAKE_ARM]) begin
         d.rx_active = 1'b0;
         d.rx_count  = 5'd0;
      end else if (!q.rx_active) begin
         if (fall) begin
            d.rx_active = 1'b1;
            d.rx_count  = RX_FRAME_TICKS - 5'd1;
         end
      end else if (tick) begin
         if (q.rx_count == 5'd0) begin
            d.rx_active = 1'b0;
         end else begin
            d.rx_count = q.rx_count - 5'd1;
         end
      end

      // register reads; a read of the receive buffer is the flag acknowledge
      if (i_rd_stb) begin
         if (i_addr == OFS_TX_CONTROL_STATUS) begin
            d.rd_data = (q.tx_ctrl & MASK_TX_CONTROL);
            d.rd_data[BIT_SHIFTER_EMPTY] = (q.state == ST_IDLE);
         end else if (i_addr == OFS_RX_CONTROL_STATUS) begin
            d.rd_data = q.rx_ctrl & MASK_RX_CONTROL;
         end else if (i_addr == OFS_BAUD_CONTROL) begin
            d.rd_data = q.baud_ctrl & MASK_BAUD;
            d.rd_data[BIT_RECEIVE_ACTIVE] = q.rx_active;
         end else if (i_addr == OFS_TX_HOLDING) begin
            d.rd_data = q.hold_data;
         end else if (i_addr == OFS_DIVIDER_HIGH_BYTE) begin
            d.rd_data = q.div_high;
         end else if (i_addr == OFS_DIVIDER_LOW_BYTE) begin
            d.rd_data = q.div_low;
         end else if (i_addr == OFS_PERIPHERAL_FLAGS) begin
            d.rd_data[BIT_RECEIVE_FLAG]  = q.rx_flag;
            d.rd_data[BIT_TRANSMIT_FLAG] = ~q.hold_full;
         end else if (i_addr == OFS_PERIPHERAL_ENABLES) begin
            d.rd_data = q.enables & MASK_PERIPH;
         end else if (i_addr == OFS_PERIPHERAL_PRIORITY) begin
            d.rd_data = q.prio & MASK_PERIPH;
         end else if (i_addr == OFS_RECEIVE_BUFFER) begin
            // filler byte, read clears the wake receive flag
            d.rd_data = 8'h00;
            d.rx_flag = 1'b0;
         end else begin
            d.rd_data = 8'h00;
         end
      end

      // register writes; the flags register and the shifter take no writes
      // no address reaches the shifter
      if (i_wr_stb) begin
         if (i_addr == OFS_TX_CONTROL_STATUS) begin
            d.tx_ctrl = i_wr_data & MASK_TX_CONTROL;
         end else if (i_addr == OFS_RX_CONTROL_STATUS) begin
            d.rx_ctrl = i_wr_data & MASK_RX_CONTROL;
         end else if (i_addr == OFS_BAUD_CONTROL) begin
            d.baud_ctrl = i_wr_data & MASK_BAUD;
            if (i_wr_data[BIT_WAKE_ARM]) begin
               d.wake_seen = 1'b0;
            end
         end else if (i_addr == OFS_TX_HOLDING) begin
            // a new byte is the only clear of transmit_flag
            d.hold_data  = i_wr_data;
            d.hold_ninth = q.tx_ctrl[BIT_NINTH_BIT_VALUE];
            d.hold_full  = 1'b1;
         end else if (i_addr == OFS_DIVIDER_HIGH_BYTE) begin
            d.div_high = i_wr_data;
         end else if (i_addr == OFS_DIVIDER_LOW_BYTE) begin
            d.div_low = i_wr_data;
         end else if (i_addr == OFS_PERIPHERAL_ENABLES) begin
            d.enables = i_wr_data & MASK_PERIPH;
         end else if (i_addr == OFS_PERIPHERAL_PRIORITY) begin
            d.prio = i_wr_data & MASK_PERIPH;
         end
      end

      // armed port watches edges only; placed last so the set wins
      if (q.baud_ctrl[BIT_WAKE_ARM] && port_on) begin
         // first transition raises the receive flag
         if (fall) begin
            d.rx_flag   = 1'b1;
            d.wake_seen = 1'b1;
         end
         if (rise && q.wake_seen) begin
            d.baud_ctrl[BIT_WAKE_ARM] = 1'b0;
            d.wake_seen               = 1'b0;
         end
      end

      // flag kept in its own flop so the output needs no gate behind it
      d.tx_flag = ~d.hold_full;

      // pin drive: port off releases both pins
      if (!port_on) begin
         d.clk_pin   = 1'b0;
         d.clk_oe_n  = 1'b1;
         d.data_pin  = 1'b0;
         d.data_oe_n = 1'b1;
      end else if (lockstep) begin
         // master drives the shift clock, idle level from polarity
         d.clk_pin   = q.baud_ctrl[BIT_CLOCK_POLARITY] ^ d.sclk_active;
         d.clk_oe_n  = ~master;
         d.data_pin  = d.line;
         d.data_oe_n = ~(master & q.tx_ctrl[BIT_TRANSMIT_ENABLE]);
      end else begin
         // asynchronous: the clock pin carries the serial output
         d.clk_pin   = d.line;
         d.clk_oe_n  = ~q.tx_ctrl[BIT_TRANSMIT_ENABLE];
         d.data_pin  = 1'b0;
         d.data_oe_n = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q           <= '0;
         q.tx_ctrl   <= RST_CONTROL;
         q.rx_ctrl   <= RST_CONTROL;
         q.baud_ctrl <= RST_CONTROL;
         q.div_high  <= RST_DIVIDER;
         q.div_low   <= RST_DIVIDER;
         q.hold_full <= ~RST_TX_FLAG;
         q.tx_flag   <= RST_TX_FLAG;
         q.rx_prev   <= RST_LINE_LEVEL;
         q.state     <= ST_IDLE;
         q.line      <= RST_LINE_LEVEL;
         q.clk_oe_n  <= 1'b1;
         q.data_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_rd_data        = q.rd_data;
   assign o_data_line      = q.data_pin;
   assign o_data_line_oe_n = q.data_oe_n;
   assign o_clock_pin      = q.clk_pin;
   assign o_clock_pin_oe_n = q.clk_oe_n;
   // transmit flag is a plain status, independent of its enable
   assign o_transmit_flag  = q.tx_flag;
   assign o_receive_flag   = q.rx_flag;

endmodule : serial_break_sync_master_tx

// ---- serial_break_sync_master_tx_sva.sv ----
// assertions on the top ports of the serial port transmit core
// assumes mode bits change only by software writes, shadowed here from the port
`timescale 1ns/1ps
module serial_break_sync_master_tx_sva
   import serial_pkg::*;
(
   input wire logic       i_core_clk,
   input wire logic       i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic       i_wr_stb,
   input wire logic       i_rd_stb,
   input wire logic [7:0] o_rd_data,
   input wire logic       i_receive_data_pin,
   input wire logic       o_data_line,
   input wire logic       o_data_line_oe_n,
   input wire logic       o_clock_pin,
   input wire logic       o_clock_pin_oe_n,
   input wire logic       o_transmit_flag,
   input wire logic       o_receive_flag
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] ctl_q;
   logic [7:0] rxc_q;
   logic [7:0] baud_q;
   logic [5:0] pin_q;
   logic [9:0] quiet_q;
   logic       hold_wr_q;
   logic       sync_on;
   logic       async_on;
   assign sync_on  = rxc_q[BIT_PORT_ENABLE] && ctl_q[BIT_LOCKSTEP] && ctl_q[BIT_CLOCK_SOURCE];
   assign async_on = rxc_q[BIT_PORT_ENABLE] && !ctl_q[BIT_LOCKSTEP];
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_q     <= 8'h00;
         rxc_q     <= 8'h00;
         baud_q    <= 8'h00;
         pin_q     <= 6'h3f;
         quiet_q   <= 10'h000;
         hold_wr_q <= 1'b0;
      end else begin
         if (i_wr_stb && i_addr == OFS_TX_CONTROL_STATUS) ctl_q <= i_wr_data;
         if (i_wr_stb && i_addr == OFS_RX_CONTROL_STATUS) rxc_q <= i_wr_data;
         if (i_wr_stb && i_addr == OFS_BAUD_CONTROL) baud_q <= i_wr_data;
         pin_q     <= {pin_q[4:0], i_receive_data_pin};
         hold_wr_q <= i_wr_stb && i_addr == OFS_TX_HOLDING;
         // saturating, so a long quiet spell means every queued frame has ended
         quiet_q   <= i_wr_stb ? 10'h000 : (quiet_q == 10'h3ff ? quiet_q : quiet_q + 10'h001);
      end
   end
   a_rdata_idle: assert property (!$past(i_rd_stb) |-> o_rd_data == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_flag_write_drop: assert property (i_wr_stb && i_addr == OFS_TX_HOLDING |=> !o_transmit_flag)
      else $error("transmit flag stayed up after holding write");
   a_flag_fall_cause: assert property ($fell(o_transmit_flag) |-> hold_wr_q)
      else $error("transmit flag fell without holding write");
   a_rx_read_clear: assert property (i_rd_stb && i_addr == OFS_RECEIVE_BUFFER && (&pin_q) |=> !o_receive_flag)
      else $error("receive flag survived buffer read");
   a_rx_set_edge: assert property ($rose(o_receive_flag) |-> !(&pin_q))
      else $error("receive flag rose without falling edge");
   a_async_dt_free: assert property (async_on [*2] |-> o_data_line_oe_n)
      else $error("data pin driven in asynchronous mode");
   a_sync_ck_drive: assert property (sync_on [*2] |-> !o_clock_pin_oe_n)
      else $error("clock pin not driven in master mode");
   a_sync_dt_drive: assert property ((sync_on && ctl_q[BIT_TRANSMIT_ENABLE]) [*2] |-> !o_data_line_oe_n)
      else $error("data pin not driven while transmitting");
   a_clock_idle_pol: assert property (sync_on && quiet_q == 10'h3ff |-> o_clock_pin == baud_q[BIT_CLOCK_POLARITY])
      else $error("idle clock level differs from polarity");
endmodule : serial_break_sync_master_tx_sva
bind serial_break_sync_master_tx serial_break_sync_master_tx_sva u_sva (
   .i_core_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data, .i_receive_data_pin,
   .o_data_line, .o_data_line_oe_n, .o_clock_pin, .o_clock_pin_oe_n, .o_transmit_flag, .o_receive_flag
);

// ---- lin_node_model.sv ----
// far-side node: listens on the resolved tx/clock and data wires, drives the rx wire
// assumes a bit time of 80 ns on the asynchronous line
`timescale 1ns/1ps
module lin_node_model #(
   parameter int BIT_NS = 80
) (
   input  wire logic i_ck,
   input  wire logic i_dt,
   input  wire logic i_sync,
   input  wire logic i_pol,
   output logic      o_rx
);
   logic [13:0] frm [8];
   logic [8:0]  sbits = 9'h000;
   int          nf = 0;
   int          sn = 0;
   initial o_rx = 1'b1;
   // moves off the core edge so the device never races it
   task automatic drive(input logic v);
      #2 o_rx = v;
   endtask : drive
   // mid-bit samples; a frame with a low stop bit runs on as a break
   always @(negedge i_ck) begin
      if (!i_sync) begin
         frm[nf % 8] = 14'h3fff;
         #(BIT_NS / 2);
         for (int k = 0; k < 14; k++) begin
            if (k < 10 || !frm[nf % 8][9]) begin
               if (k > 0) #(BIT_NS);
               frm[nf % 8][k] = i_ck;
            end
         end
         nf++;
      end
   end
   // data taken as the clock returns to its idle level
   always @(i_ck) begin
      if (i_sync && i_ck === i_pol && sn < 9) begin
         sbits[sn] = i_dt;
         sn++;
      end
   end
endmodule : lin_node_model

// ---- tb_serial_break_sync_master_tx.sv ----
// self-checking bench for the serial port transmit core
// drives the register port at the rising edge and resolves both two-way pins
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module tb_serial_break_sync_master_tx;
   import serial_pkg::*;
   logic       i_core_clk = 1'b0;
   logic       i_rst_n    = 1'b0;
   logic [3:0] i_addr     = 4'h0;
   logic [7:0] i_wr_data  = 8'h00;
   logic       i_wr_stb   = 1'b0;
   logic       i_rd_stb   = 1'b0;
   logic [7:0] o_rd_data;
   logic       o_data_line;
   logic       o_data_line_oe_n;
   logic       o_clock_pin;
   logic       o_clock_pin_oe_n;
   logic       o_transmit_flag;
   logic       o_receive_flag;
   logic       node_rx;
   logic       sync_md    = 1'b0;
   logic       pol        = 1'b0;
   logic       ck_w;
   logic       dt_w;
   int         fail_count = 0;
   int         tests_run  = 0;
   // a released clock pin is pulled high; a released data pin carries the node's rx
   assign ck_w = o_clock_pin_oe_n ? 1'b1 : o_clock_pin;
   assign dt_w = o_data_line_oe_n ? node_rx : o_data_line;
   serial_break_sync_master_tx u_dut (
      .i_core_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
      .i_receive_data_pin(dt_w), .o_data_line, .o_data_line_oe_n, .o_clock_pin, .o_clock_pin_oe_n,
      .o_transmit_flag, .o_receive_flag
   );
   lin_node_model u_node (.i_ck(ck_w), .i_dt(dt_w), .i_sync(sync_md), .i_pol(pol), .o_rx(node_rx));
   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_stb  <= 1'b1;
      @(posedge i_core_clk);
      i_wr_stb  <= 1'b0;
      @(posedge i_core_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      i_addr   <= a;
      i_rd_stb <= 1'b1;
      @(posedge i_core_clk);
      i_rd_stb <= 1'b0;
      #1;
      `CHK(o_rd_data, exp)
      @(posedge i_core_clk);
   endtask : rd
   // sel picks the model's counter: 0 async frames, 1 synchronous bits
   task automatic wait_for(input logic sel, input int n);
      for (int k = 0; k < 4000 && (sel ? u_node.sn : u_node.nf) < n; k++) @(posedge i_core_clk);
      `CHK((sel ? u_node.sn : u_node.nf) >= n, 1'b1)
   endtask : wait_for
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end
   initial begin
      cyc(20);
      i_rst_n <= 1'b1;
      cyc(1);
      rd(OFS_PERIPHERAL_FLAGS, 8'h10);
      rd(OFS_TX_CONTROL_STATUS, 8'h02);
      rd(4'hf, 8'h00);
      wr(OFS_PERIPHERAL_FLAGS, 8'h00);
      rd(OFS_PERIPHERAL_FLAGS, 8'h10);
      wr(OFS_DIVIDER_HIGH_BYTE, 8'h01);
      rd(OFS_DIVIDER_HIGH_BYTE, 8'h01);
      wr(OFS_DIVIDER_LOW_BYTE, 8'h03);
      wr(OFS_RX_CONTROL_STATUS, 8'h80);
      wr(OFS_TX_CONTROL_STATUS, 8'h20);
      wr(OFS_TX_HOLDING, 8'ha6);
      wr(OFS_TX_HOLDING, 8'h3c);
      rd(OFS_PERIPHERAL_FLAGS, 8'h00);
      `CHK(o_transmit_flag, 1'b0)
      rd(OFS_TX_CONTROL_STATUS, 8'h20);
      wait_for(1'b0, 2);
      `CHK(u_node.frm[0], {5'h1f, 8'ha6, 1'b0})
      `CHK(u_node.frm[1], {5'h1f, 8'h3c, 1'b0})
      cyc(20);
      rd(OFS_TX_CONTROL_STATUS, 8'h22);
      rd(OFS_PERIPHERAL_FLAGS, 8'h10);
      wr(OFS_TX_CONTROL_STATUS, 8'h28);
      wr(OFS_TX_HOLDING, 8'hff);
      wr(OFS_TX_HOLDING, 8'h55);
      rd(OFS_TX_CONTROL_STATUS, 8'h28);
      wait_for(1'b0, 4);
      `CHK(u_node.frm[2], 14'h2000)
      `CHK(u_node.frm[3], {5'h1f, 8'h55, 1'b0})
      cyc(20);
      rd(OFS_TX_CONTROL_STATUS, 8'h22);
      rd(OFS_PERIPHERAL_FLAGS, 8'h10);
      wr(OFS_BAUD_CONTROL, 8'h01);
      rd(OFS_BAUD_CONTROL, 8'h01);
      wr(OFS_BAUD_CONTROL, 8'h00);
      u_node.drive(1'b0);
      cyc(6);
      wr(OFS_TX_HOLDING, 8'h81);
      rd(OFS_BAUD_CONTROL, 8'h40);
      rd(OFS_TX_CONTROL_STATUS, 8'h22);
      u_node.drive(1'b1);
      wait_for(1'b0, 5);
      `CHK(u_node.frm[4], {5'h1f, 8'h81, 1'b0})
      cyc(20);
      wr(OFS_BAUD_CONTROL, 8'h02);
      rd(OFS_BAUD_CONTROL, 8'h02);
      u_node.drive(1'b0);
      cyc(8);
      rd(OFS_PERIPHERAL_FLAGS, 8'h30);
      `CHK(o_receive_flag, 1'b1)
      rd(OFS_BAUD_CONTROL, 8'h02);
      u_node.drive(1'b1);
      cyc(8);
      rd(OFS_BAUD_CONTROL, 8'h00);
      rd(OFS_RECEIVE_BUFFER, 8'h00);
      rd(OFS_PERIPHERAL_FLAGS, 8'h10);
      `CHK(o_receive_flag, 1'b0)
      `CHK(o_transmit_flag, 1'b1)
      sync_md = 1'b1;
      pol     = 1'b1;
      wr(OFS_BAUD_CONTROL, 8'h10);
      wr(OFS_TX_CONTROL_STATUS, 8'hb0);
      cyc(4);
      `CHK(ck_w, 1'b1)
      `CHK(o_data_line_oe_n, 1'b0)
      u_node.sn = 0;
      wr(OFS_TX_HOLDING, 8'hc5);
      wait_for(1'b1, 8);
      `CHK(u_node.sbits[7:0], 8'hc5)
      cyc(100);
      pol = 1'b0;
      wr(OFS_BAUD_CONTROL, 8'h00);
      wr(OFS_TX_CONTROL_STATUS, 8'hf1);
      cyc(4);
      `CHK(ck_w, 1'b0)
      u_node.sn = 0;
      wr(OFS_TX_HOLDING, 8'h3a);
      wait_for(1'b1, 9);
      `CHK(u_node.sbits, {1'b1, 8'h3a})
      cyc(1040);
      print_verdict();
   end
endmodule : tb_serial_break_sync_master_tx
